/* File: hdl/irq_ctrl_regs.svh */
// Register offsets, field positions, reset values and timing counts of the interrupt controller
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH

// ****************************************
// Word addresses on the register bus
// ****************************************
`define REG_MISC0_ADDR    4'h0
`define REG_TIMER_ADDR    4'h1
`define REG_PERIPH_ADDR   4'h2
`define REG_MISC_ADDR     4'h3
`define REG_GROUPED_ADDR  4'h4
`define REG_EDGE_ADDR     4'h5
`define REG_PSC0_ADDR     4'h6
`define REG_PSC1_ADDR     4'h7
`define REG_TB0_ADDR      4'h8
`define REG_TB1_ADDR      4'h9
`define REG_CORE_ADDR     4'hA

// ****************************************
// Field layout, masks and reset value
// ****************************************
`define FLAG_LSB          4
`define MISC0_MASK        8'h7F
`define MISC_MASK         8'hBB
`define GROUPED_MASK      8'h33
`define EDGE_MASK         8'h03
`define PSC_MASK          8'h03
`define TB_MASK           8'h87
`define REG_RESET         8'h00
`define GIE_BIT           0

// ****************************************
// Edge and prescaler codes, tick exponent and stack depth
// ****************************************
`define EDGE_OFF          2'h0
`define EDGE_RISE         2'h1
`define EDGE_FALL         2'h2
`define EDGE_BOTH         2'h3
`define PSC_SYS           2'h0
`define PSC_SYS4          2'h1
`define TICK_MIN_EXP      8
`define STACK_DEPTH       4'h8

`endif

/* File: hdl/irq_ctrl_pkg.sv */
// Types shared by the interrupt controller
package irq_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_RUN    = 3'b001,
    ST_VECTOR = 3'b010,
    ST_SLEEP  = 3'b100
  } core_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic       read;
    logic       write;
    logic [7:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] source;
  } vector_t;
endpackage

/* File: hdl/irq_ctrl.sv */
// Interrupt controller with flags, enables, priority, stack guard and time bases
`timescale 1ns/1ns
`include "irq_ctrl_regs.svh"

module irq_ctrl (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  clk_en,
  // Avalon-MM slave
  input  wire logic [3:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  // Source events, one-cycle pulses
  input  wire logic [3:0]            timer_match_evt,
  input  wire logic [3:0]            periph_evt,
  input  wire logic                  converter_evt,
  input  wire logic [1:0]            ptimer1_match_evt,
  input  wire logic                  slot_overflow_evt,
  input  wire logic                  scan_done_evt,
  input  wire logic                  sub_clk_tick,
  // External pin
  input  wire logic                  ext_pin,
  input  wire logic                  ext_pin_func_sel,
  input  wire logic                  ext_pin_is_input,
  input  wire logic                  ext_pin_pullup_sel,
  output logic                       ext_pin_pullup_en,
  // Core sequencer
  input  wire logic                  instr_done,
  input  wire logic                  return_from_irq_instr,
  input  wire logic                  enter_sleep,
  input  wire logic [12:0]           next_pc,
  output logic                       irq_take,
  output logic      [12:0]           vector_addr,
  output logic      [12:0]           return_pc,
  output logic                       return_valid,
  output logic                       wake
);
  import irq_ctrl_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0]  misc0_q, misc0_d, timer_q, timer_d, periph_q, periph_d;
  logic [7:0]  misc_q, misc_d, grouped_q, grouped_d;
  logic [1:0]  edge_q, edge_d;
  logic [1:0]  psc0_q, psc0_d, psc1_q, psc1_d;
  logic [3:0]  tb0_q, tb0_d, tb1_q, tb1_d;
  logic        pin_q, pin_d;
  logic [1:0]  sys4_q, sys4_d;
  logic [15:0] div0_q, div0_d, div1_q, div1_d;
  logic [15:0] flags_prev_q, flags_prev_d;
  logic [3:0]  sp_q, sp_d;
  logic [12:0] stack_q [0:7];
  logic [12:0] stack_d [0:7];
  core_state_t state_q, state_d;
  logic [31:0] rdata_q, rdata_d;
  logic        wait_q, wait_d;
  logic        irq_q, irq_d, ret_q, ret_d, wake_q, wake_d, pull_q, pull_d;
  logic [12:0] vec_q, vec_d, rpc_q, rpc_d;

  bus_req_t    req;
  vector_t     pick;
  logic [15:0] flags, enables, pending;
  logic        wr, pin_act, pin_rise, pin_fall, ext_evt, tb0_evt, tb1_evt;
  logic        stack_full, take;
  logic [7:0]  wbyte;

  assign req   = '{addr: avs_address, read: avs_read, write: avs_write,
                   wdata: avs_writedata[7:0]};
  // Write lands only at the edge where waitrequest is seen low
  assign wr    = req.write && !wait_q && clk_en;
  assign wbyte = req.wdata;

  // ****************************************
  // Pin and time base event detection
  // ****************************************
  always_comb begin
    pin_act  = misc0_q[1] && ext_pin_func_sel && ext_pin_is_input;
    pin_rise = pin_act && ext_pin && !pin_q;
    pin_fall = pin_act && !ext_pin && pin_q;
    case (edge_q)
      `EDGE_RISE: ext_evt = pin_rise;
      `EDGE_FALL: ext_evt = pin_fall;
      `EDGE_BOTH: ext_evt = pin_rise || pin_fall;
      default:    ext_evt = 1'b0;
    endcase
    pin_d  = ext_pin;
    sys4_d = sys4_q + 2'h1;
  end

  function automatic logic tick_clk(input logic [1:0] src, input logic s4, input logic sub);
    case (src)
      `PSC_SYS:  tick_clk = 1'b1;
      `PSC_SYS4: tick_clk = s4;
      default:   tick_clk = sub;
    endcase
  endfunction

  always_comb begin
    logic c0, c1;
    c0 = tb0_q[3] && tick_clk(psc0_q, sys4_q == 2'h3, sub_clk_tick);
    c1 = tb1_q[3] && tick_clk(psc1_q, sys4_q == 2'h3, sub_clk_tick);
    div0_d  = tb0_q[3] ? div0_q + {15'h0000, c0} : 16'h0000;
    div1_d  = tb1_q[3] ? div1_q + {15'h0000, c1} : 16'h0000;
    // Overflow of bit selected by period field
    tb0_evt = c0 && (div0_q[`TICK_MIN_EXP - 1 + tb0_q[2:0]] &&
              !div0_d[`TICK_MIN_EXP - 1 + tb0_q[2:0]]);
    tb1_evt = c1 && (div1_q[`TICK_MIN_EXP - 1 + tb1_q[2:0]] &&
              !div1_d[`TICK_MIN_EXP - 1 + tb1_q[2:0]]);
  end

  // ****************************************
  // Priority and acceptance
  // ****************************************
  // Order: ext, touch, tick0, timer x4, periph x4, converter, tick1, grouped
  assign flags   = {2'h0, misc_q[7], misc_q[5], misc_q[4], periph_q[7:4], timer_q[7:4],
                    misc0_q[6], misc0_q[5], misc0_q[4]};
  assign enables = {2'h0, misc_q[3], misc_q[1], misc_q[0], periph_q[3:0], timer_q[3:0],
                    misc0_q[3], misc0_q[2], misc0_q[1]};
  assign pending = flags & enables;
  assign stack_full = (sp_q == `STACK_DEPTH);

  always_comb begin
    pick = '{valid: 1'b0, source: 16'h0000};
    for (int i = 15; i >= 0; i--) begin
      if (pending[i]) begin
        pick.valid  = 1'b1;
        pick.source = 16'h0001 << i;
      end
    end
  end

  assign take = pick.valid && misc0_q[`GIE_BIT] && !stack_full
                && instr_done && (state_q == ST_RUN);

  // ****************************************
  // Register file next state
  // ****************************************
  always_comb begin
    misc0_d   = misc0_q;
    timer_d   = timer_q;
    periph_d  = periph_q;
    misc_d    = misc_q;
    grouped_d = grouped_q;
    edge_d    = edge_q;
    psc0_d    = psc0_q;
    psc1_d    = psc1_q;
    tb0_d     = tb0_q;
    tb1_d     = tb1_q;
    if (wr) begin
      case (req.addr)
        `REG_MISC0_ADDR:   misc0_d   = wbyte & `MISC0_MASK;
        `REG_TIMER_ADDR:   timer_d   = wbyte;
        `REG_PERIPH_ADDR:  periph_d  = wbyte;
        `REG_MISC_ADDR:    misc_d    = wbyte & `MISC_MASK;
        `REG_GROUPED_ADDR: grouped_d = wbyte & `GROUPED_MASK;
        `REG_EDGE_ADDR:    edge_d    = wbyte[1:0];
        `REG_PSC0_ADDR:    psc0_d    = wbyte[1:0];
        `REG_PSC1_ADDR:    psc1_d    = wbyte[1:0];
        `REG_TB0_ADDR:     tb0_d     = {wbyte[7], wbyte[2:0]};
        `REG_TB1_ADDR:     tb1_d     = {wbyte[7], wbyte[2:0]};
        default: ;
      endcase
    end
    // Service clears only the serviced flag and the global enable
    if (take) begin
      misc0_d[`GIE_BIT] = 1'b0;
      if (pick.source[0]) misc0_d[4] = 1'b0;
      if (pick.source[1]) misc0_d[5] = 1'b0;
      if (pick.source[2]) misc0_d[6] = 1'b0;
      timer_d[7:4]  = timer_d[7:4]  & ~pick.source[6:3];
      periph_d[7:4] = periph_d[7:4] & ~pick.source[10:7];
      if (pick.source[11]) misc_d[4] = 1'b0;
      if (pick.source[12]) misc_d[5] = 1'b0;
      if (pick.source[13]) misc_d[7] = 1'b0;
    end
    // Hardware sets win over clears, except the grouped flag misc_q[7] in the cycle it is serviced
    if (ext_evt) misc0_d[4] = 1'b1;
    if (slot_overflow_evt || scan_done_evt) misc0_d[5] = 1'b1;
    if (tb0_evt) misc0_d[6] = 1'b1;
    timer_d[7:4]   = timer_d[7:4]  | timer_match_evt;
    periph_d[7:4]  = periph_d[7:4] | periph_evt;
    if (converter_evt) misc_d[4] = 1'b1;
    if (tb1_evt) misc_d[5] = 1'b1;
    grouped_d[5:4] = grouped_d[5:4] | ptimer1_match_evt;
    if (|(grouped_q[5:4] & grouped_q[1:0]) && !(take && pick.source[13]))
      misc_d[7] = 1'b1;
  end

  // ****************************************
  // Stack, core handshake and sleep
  // ****************************************
  always_comb begin
    logic [15:0] newly;
    newly   = flags & ~flags_prev_q;
    sp_d    = sp_q;
    stack_d = stack_q;
    state_d = state_q;
    irq_d   = 1'b0;
    ret_d   = 1'b0;
    vec_d   = vec_q;
    rpc_d   = rpc_q;
    flags_prev_d = flags;
    wake_d  = 1'b0;
    pull_d  = pin_act && ext_pin_pullup_sel;
    case (state_q)
      ST_RUN: begin
        if (take) begin
          stack_d[sp_q[2:0]] = next_pc;
          sp_d    = sp_q + 4'h1;
          state_d = ST_VECTOR;
          irq_d   = 1'b1;
          vec_d   = {7'h00, pick_index(pick.source), 2'h0} + 13'h0004;
        end else if (return_from_irq_instr && sp_q != 4'h0) begin
          sp_d  = sp_q - 4'h1;
          rpc_d = stack_q[sp_q[2:0] - 3'h1];
          ret_d = 1'b1;
        end else if (enter_sleep) begin
          state_d = ST_SLEEP;
        end
      end
      ST_VECTOR: state_d = ST_RUN;
      ST_SLEEP: begin
        if (|newly) begin
          wake_d  = 1'b1;
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  function automatic logic [3:0] pick_index(input logic [15:0] s);
    pick_index = 4'h0;
    for (int i = 0; i < 16; i++) if (s[i]) pick_index = i[3:0];
  endfunction

  // ****************************************
  // Bus answer: one wait cycle then data
  // ****************************************
  always_comb begin
    rdata_d = 32'h0000_0000;
    wait_d  = 1'b1;
    if ((req.read || req.write) && wait_q) begin
      wait_d = 1'b0;
      case (req.addr)
        `REG_MISC0_ADDR:   rdata_d[7:0] = misc0_q;
        `REG_TIMER_ADDR:   rdata_d[7:0] = timer_q;
        `REG_PERIPH_ADDR:  rdata_d[7:0] = periph_q;
        `REG_MISC_ADDR:    rdata_d[7:0] = misc_q & `MISC_MASK;
        `REG_GROUPED_ADDR: rdata_d[7:0] = grouped_q & `GROUPED_MASK;
        `REG_EDGE_ADDR:    rdata_d[7:0] = {6'h00, edge_q};
        `REG_PSC0_ADDR:    rdata_d[7:0] = {6'h00, psc0_q};
        `REG_PSC1_ADDR:    rdata_d[7:0] = {6'h00, psc1_q};
        `REG_TB0_ADDR:     rdata_d[7:0] = {tb0_q[3], 4'h0, tb0_q[2:0]};
        `REG_TB1_ADDR:     rdata_d[7:0] = {tb1_q[3], 4'h0, tb1_q[2:0]};
        `REG_CORE_ADDR:    rdata_d[7:0] = {1'b0, state_q, sp_q};
        default:           rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      misc0_q      <= `REG_RESET;
      timer_q      <= `REG_RESET;
      periph_q     <= `REG_RESET;
      misc_q       <= `REG_RESET;
      grouped_q    <= `REG_RESET;
      edge_q       <= 2'h0;
      psc0_q       <= 2'h0;
      psc1_q       <= 2'h0;
      tb0_q        <= 4'h0;
      tb1_q        <= 4'h0;
      pin_q        <= 1'b0;
      sys4_q       <= 2'h0;
      div0_q       <= 16'h0000;
      div1_q       <= 16'h0000;
      flags_prev_q <= 16'h0000;
      sp_q         <= 4'h0;
      state_q      <= ST_RUN;
      rdata_q      <= 32'h0000_0000;
      wait_q       <= 1'b1;
      irq_q        <= 1'b0;
      ret_q        <= 1'b0;
      wake_q       <= 1'b0;
      pull_q       <= 1'b0;
      vec_q        <= 13'h0000;
      rpc_q        <= 13'h0000;
      for (int i = 0; i < 8; i++) stack_q[i] <= 13'h0000;
    end else if (clk_en) begin
      misc0_q      <= misc0_d;
      timer_q      <= timer_d;
      periph_q     <= periph_d;
      misc_q       <= misc_d;
      grouped_q    <= grouped_d;
      edge_q       <= edge_d;
      psc0_q       <= psc0_d;
      psc1_q       <= psc1_d;
      tb0_q        <= tb0_d;
      tb1_q        <= tb1_d;
      pin_q        <= pin_d;
      sys4_q       <= sys4_d;
      div0_q       <= div0_d;
      div1_q       <= div1_d;
      flags_prev_q <= flags_prev_d;
      sp_q         <= sp_d;
      state_q      <= state_d;
      rdata_q      <= rdata_d;
      wait_q       <= wait_d;
      irq_q        <= irq_d;
      ret_q        <= ret_d;
      wake_q       <= wake_d;
      pull_q       <= pull_d;
      vec_q        <= vec_d;
      rpc_q        <= rpc_d;
      for (int i = 0; i < 8; i++) stack_q[i] <= stack_d[i];
    end
  end

  assign avs_readdata      = rdata_q;
  assign avs_waitrequest   = wait_q;
  assign irq_take          = irq_q;
  assign vector_addr       = vec_q;
  assign return_pc         = rpc_q;
  assign return_valid      = ret_q;
  assign wake              = wake_q;
  assign ext_pin_pullup_en = pull_q;

  // ****************************************
  // Assertions
  // ****************************************
  a_gie_blocks: assert property (@(posedge clk) disable iff (reset)
    (clk_en && !misc0_q[0]) |=> !irq_take) else $error("interrupt taken with global off");
  a_enable_gate: assert property (@(posedge clk) disable iff (reset)
    take |-> |(pick.source & enables)) else $error("disabled source taken");
  a_gie_cleared: assert property (@(posedge clk) disable iff (reset)
    (take && clk_en && !wr) |=> !misc0_q[0]) else $error("global enable not cleared");
  a_full_stack: assert property (@(posedge clk) disable iff (reset)
    stack_full |-> !take) else $error("take with full stack");
  a_push_once: assert property (@(posedge clk) disable iff (reset)
    (take && clk_en) |=> (sp_q == $past(sp_q) + 4'h1) && irq_take)
    else $error("stack not pushed");
  a_flag_set: assert property (@(posedge clk) disable iff (reset)
    (clk_en && converter_evt) |=> misc_q[4]) else $error("converter flag lost");
  a_ext_rise: assert property (@(posedge clk) disable iff (reset)
    (clk_en && pin_rise && edge_q == `EDGE_RISE) |=> misc0_q[4]) else $error("edge missed");
  a_ext_off: assert property (@(posedge clk) disable iff (reset)
    (edge_q == `EDGE_OFF) |-> !ext_evt) else $error("disabled edge fired");
  a_priority: assert property (@(posedge clk) disable iff (reset)
    pick.valid |-> ((pick.source - 16'h0001) & pending) == 16'h0000)
    else $error("lower priority chosen");
  a_grouped_kept: assert property (@(posedge clk) disable iff (reset)
    (take && clk_en && pick.source[13] && !wr) |=>
      grouped_q[5:4] == ($past(grouped_q[5:4]) | $past(ptimer1_match_evt)))
    else $error("grouped flags cleared by service");
  a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
    (misc_q & ~`MISC_MASK) == 8'h00) else $error("reserved bits set");

  c_take: cover property (@(posedge clk) irq_take);
  c_return: cover property (@(posedge clk) return_valid);
  c_wake: cover property (@(posedge clk) wake);
  c_full: cover property (@(posedge clk) stack_full && pick.valid);
endmodule

/* File: tb/core_model.sv */
// Behavioural core sequencer holding the program counter and return stack
`timescale 1ns/1ns

module core_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Controller side
  input  wire logic        irq_take,
  input  wire logic [12:0] vector_addr,
  output logic             instr_done,
  output logic             return_from_irq_instr,
  output logic      [12:0] next_pc,
  // Bench side
  input  wire logic        ret_req,
  input  wire logic [12:0] base_pc,
  output logic      [12:0] pop_pc
);
  logic [12:0] stack_q[$];

  // PC only moves on a jump, so the pushed value is the same in every cycle
  always @(posedge clk) begin
    if (reset) begin
      stack_q.delete();
      next_pc <= base_pc;
      pop_pc <= 13'h0000;
      instr_done <= 1'b1;
      return_from_irq_instr <= 1'b0;
    end else begin
      return_from_irq_instr <= ret_req;
      if (irq_take === 1'b1) begin
        stack_q.push_back(next_pc);
        next_pc <= vector_addr + 13'h0001;
      end else if (return_from_irq_instr && stack_q.size() > 0) begin
        pop_pc <= stack_q[$];
        next_pc <= stack_q[$];
        stack_q.pop_back();
      end
    end
  end
endmodule

/* File: tb/tb_irq_ctrl.sv */
// Self-checking bench for the interrupt controller
`timescale 1ns/1ns
`include "irq_ctrl_regs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end

module tb_irq_ctrl;
  logic        clk, reset, avs_read, avs_write, avs_waitrequest, irq_take, return_valid, wake;
  logic        ext_pin, func_sel, is_in, pu_sel, pu_en, enter_sleep, ret_req, sub_tick;
  logic        instr_done, ret_instr;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [12:0] next_pc, vector_addr, return_pc, pop_pc, base_pc, ev;
  logic [12:0] takes[$];
  logic [11:0] e;
  logic [7:0]  rd;
  int          bad_count, n_compared, cyc, wakes, seed;

  irq_ctrl u_dut (
    .clk(clk), .reset(reset), .clk_en(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .timer_match_evt(ev[3:0]), .periph_evt(ev[7:4]), .converter_evt(ev[8]),
    .ptimer1_match_evt(ev[10:9]), .slot_overflow_evt(ev[11]), .scan_done_evt(ev[12]),
    .sub_clk_tick(sub_tick), .ext_pin(ext_pin), .ext_pin_func_sel(func_sel),
    .ext_pin_is_input(is_in), .ext_pin_pullup_sel(pu_sel), .ext_pin_pullup_en(pu_en),
    .instr_done(instr_done), .return_from_irq_instr(ret_instr), .enter_sleep(enter_sleep),
    .next_pc(next_pc), .irq_take(irq_take), .vector_addr(vector_addr),
    .return_pc(return_pc), .return_valid(return_valid), .wake(wake)
  );

  core_model u_core (
    .clk(clk), .reset(reset), .irq_take(irq_take), .vector_addr(vector_addr),
    .instr_done(instr_done), .return_from_irq_instr(ret_instr), .next_pc(next_pc),
    .ret_req(ret_req), .base_pc(base_pc), .pop_pc(pop_pc)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************
  // Monitors and helpers
  // ****************************************
  always @(posedge clk) begin
    cyc++;
    sub_tick <= (cyc % 4 == 0);
    if (irq_take === 1'b1) takes.push_back(vector_addr);
    if (return_valid === 1'b1) `CHK(return_pc, pop_pc)
    if (wake === 1'b1) wakes++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    `CHK(avs_waitrequest, 1'b0)
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] x);
    bus(1'b0, a, 8'h00);
    `CHK(rd, x)
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic exp_take(input logic [12:0] v);
    int n;
    logic [12:0] g;
    n = 0;
    while (takes.size() == 0 && n < 30) begin
      @(posedge clk);
      n++;
    end
    g = (takes.size() > 0) ? takes.pop_front() : 13'hxxxx;
    `CHK(g, v)
  endtask

  task automatic no_take();
    cyc_wait(30);
    `CHK(takes.size(), 0)
  endtask

  task automatic ret();
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    cyc_wait(4);
  endtask

  task automatic pulse(input int k);
    ev <= 13'h0001 << k;
    @(posedge clk);
    ev <= 13'h0000;
    cyc_wait(3);
  endtask

  // Register and mask that a source event lands in
  function automatic logic [11:0] ev_reg(input int k);
    if (k < 4) return {4'h1, 8'h10 << k};
    if (k < 8) return {4'h2, 8'h10 << (k - 4)};
    if (k == 8) return {4'h3, 8'h10};
    if (k < 11) return {4'h4, 8'h10 << (k - 9)};
    return {4'h0, 8'h20};
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 64;
    base_pc = 13'($random(seed));
    pu_sel = 1'($random(seed));
    {reset, avs_read, avs_write, ext_pin, func_sel, is_in, enter_sleep, ret_req} <= 8'h80;
    {avs_address, avs_writedata, ev} <= '0;
    cyc_wait(3);
    reset <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 10; a++) rd_chk(a[3:0], 8'h00);
    wr(4'hB, 8'hFF);
    rd_chk(4'hB, 8'h00);
    for (int a = 1; a < 3; a++) begin
      wr(a[3:0], 8'hFF);
      rd_chk(a[3:0], 8'hFF);
      wr(a[3:0], 8'h00);
    end
    wr(`REG_MISC_ADDR, 8'hFF);
    rd_chk(`REG_MISC_ADDR, 8'hBB);
    wr(`REG_GROUPED_ADDR, 8'hFF);
    rd_chk(`REG_GROUPED_ADDR, 8'h33);
    wr(`REG_GROUPED_ADDR, 8'h00);
    wr(`REG_MISC_ADDR, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 13; k++) begin
      pulse(k);
      e = ev_reg(k);
      rd_chk(e[11:8], e[7:0]);
      wr(e[11:8], 8'h00);
    end
    $display("test events done");
    wr(4'h0, 8'h01);
    pulse(0);
    no_take();
    rd_chk(4'h1, 8'h10);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h11);
    no_take();
    wr(4'h0, 8'h01);
    exp_take(13'h0010);
    rd_chk(4'h0, 8'h00);
    ret();
    wr(4'h1, 8'h00);
    $display("test gating done");
    wr(4'h0, 8'h7F);
    exp_take(13'h0004);
    rd_chk(4'h0, 8'h6E);
    wr(4'h0, 8'h6F);
    exp_take(13'h0008);
    wr(4'h0, 8'h4F);
    exp_take(13'h000C);
    rd_chk(4'h0, 8'h0E);
    repeat (3) ret();
    wr(4'h0, 8'h00);
    $display("test priority done");
    wr(4'h4, 8'h01);
    pulse(9);
    rd_chk(4'h4, 8'h11);
    rd_chk(4'h3, 8'h80);
    wr(4'h3, 8'h88);
    wr(4'h0, 8'h01);
    exp_take(13'h0038);
    rd_chk(4'h4, 8'h11);
    wr(4'h4, 8'h00);
    wr(4'h3, 8'h00);
    ret();
    $display("test grouped done");
    for (int i = 0; i < 8; i++) begin
      wr(4'h0, 8'h13);
      exp_take(13'h0004);
    end
    wr(4'h0, 8'h13);
    no_take();
    ret();
    exp_take(13'h0004);
    repeat (8) ret();
    wr(4'h0, 8'h00);
    $display("test stack done");
    func_sel <= 1'b1;
    is_in <= 1'b1;
    wr(4'h0, 8'h02);
    for (int c = 0; c < 4; c++) begin
      wr(4'h5, c[7:0]);
      ext_pin <= 1'b1;
      cyc_wait(4);
      rd_chk(4'h0, c[0] ? 8'h12 : 8'h02);
      wr(4'h0, 8'h02);
      ext_pin <= 1'b0;
      cyc_wait(4);
      rd_chk(4'h0, c[1] ? 8'h12 : 8'h02);
      wr(4'h0, 8'h02);
    end
    `CHK(pu_en, pu_sel)
    func_sel <= 1'b0;
    ext_pin <= 1'b1;
    cyc_wait(4);
    rd_chk(4'h0, 8'h02);
    `CHK(pu_en, 1'b0)
    wr(4'h5, 8'h00);
    wr(4'h0, 8'h00);
    $display("test external done");
    for (int s = 0; s < 3; s++) begin
      wr(4'h6, s[7:0]);
      wr(4'h8, 8'h80);
      cyc_wait((s == 0 ? 256 : 1024) - 24);
      rd_chk(4'h0, 8'h00);
      cyc_wait(40);
      rd_chk(4'h0, 8'h40);
      wr(4'h8, 8'h00);
      wr(4'h0, 8'h00);
    end
    wr(4'h9, 8'h81);
    cyc_wait(512 - 24);
    rd_chk(4'h3, 8'h00);
    cyc_wait(40);
    rd_chk(4'h3, 8'h20);
    wr(4'h9, 8'h00);
    wr(4'h3, 8'h10);
    $display("test ticks done");
    enter_sleep <= 1'b1;
    @(posedge clk);
    enter_sleep <= 1'b0;
    pulse(8);
    cyc_wait(6);
    `CHK(wakes, 0)
    pulse(4);
    cyc_wait(6);
    `CHK(wakes, 1)
    wr(4'h3, 8'h00);
    wr(4'h2, 8'h00);
    $display("test sleep done");
    summarize();
  end
endmodule
